// >>> core/tss_pkg.sv
/*
 * Constants, register layout and state codes for the touch scan sequencer.
 * Assumes a 250 MHz system clock; the panel oscillator rate is a plain default.
 */
package tss_pkg;
    // AXI4-Lite map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_X = 8'h00;
    localparam logic [7:0] OFF_Y = 8'h04;
    localparam logic [7:0] OFF_Z1 = 8'h08;
    localparam logic [7:0] OFF_Z2 = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_TIME = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Control register fields
    localparam int CTRL_AUTO_BIT = 0;
    localparam int FUNC_LSB = 3;
    localparam int FUNC_MSB = 6;
    localparam int CTRL_PENFN_BIT = 7;
    localparam int CTRL_RES12_BIT = 8;
    localparam int MED_LSB = 9;
    localparam int AVG_LSB = 11;
    localparam logic [31:0] CTRL_RESET = 32'h000001f8;
    localparam logic [3:0] FUNC_XYZ = 4'h0;
    localparam logic [3:0] FUNC_XY = 4'h1;

    // Timing register fields, intervals in oscillator cycles
    localparam int PVS_LSB = 0;
    localparam int PRE_LSB = 8;
    localparam int SNS_LSB = 16;
    localparam logic [31:0] TIME_RESET = 32'h00040404;

    // Status register bits
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PEN_BIT = 1;
    localparam int STAT_DAV_BIT = 2;

    // Oscillator derived from the system clock; counts are in half oscillator cycles
    localparam int CLK_PERIOD_NS = 4;
    localparam int OSC_PERIOD_NS = 100;
    localparam int HALF_OSC_CYC = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [11:0] ADC_HALF_OSC = 12'h002;
    localparam logic [11:0] OH1_HALF = 12'h005;
    localparam logic [11:0] OH2_HALF = 12'h007;
    localparam logic [11:0] OH_DLY1_HALF = 12'h014;
    localparam logic [11:0] CONVERSION_OVERHEAD_HALF = 12'h006;

    // Preprocessing delay in oscillator cycles, 12-bit / 10-bit
    localparam logic [5:0] PPRO_M1 = 6'd2;
    localparam logic [5:0] PPRO_M3_12 = 6'd28;
    localparam logic [5:0] PPRO_M3_10 = 6'd24;
    localparam logic [5:0] PPRO_M7W3_12 = 6'd31;
    localparam logic [5:0] PPRO_M7W3_10 = 6'd27;
    localparam logic [5:0] PPRO_M15W1_12 = 6'd31;
    localparam logic [5:0] PPRO_M15W1_10 = 6'd29;
    localparam logic [5:0] PPRO_M15W3_12 = 6'd34;
    localparam logic [5:0] PPRO_M15W3_10 = 6'd32;
    localparam logic [5:0] PPRO_M15W7_12 = 6'd38;
    localparam logic [5:0] PPRO_M15W7_10 = 6'd36;
    localparam int MAX_SAMP = 16;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OVH = 3'b001,
        ST_SETTLE = 3'b010,
        ST_CONV = 3'b011,
        ST_PPRO = 3'b100
    } tss_state_t;

    typedef enum logic [1:0] {
        CO_Y = 2'b00,
        CO_X = 2'b01,
        CO_Z1 = 2'b10,
        CO_Z2 = 2'b11
    } tss_coord_t;
endpackage : tss_pkg

// >>> core/tss_core.sv
/*
 * Touch scan sequencer: AXI4-Lite register slave, scan state machine,
 * converter timing and median/average filter, all in one module.
 * Assumes pen_touch and adc_result are synchronous to aclk and that the
 * converter result is valid whenever adc_sample pulses.
 */
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
// Summary of operation
// - Function code 0000 is X-Y-Z scan, 0001 is X-Y scan, bits 6:3.
// - Pen touch pulls the interrupt pin low when configured for pen use.
// - Self-initiated mode runs the chosen scan after a touch without host action.
// - Scan start enables Y drivers, waits stabilization, then converts Y.
// - With preprocessing, several conversions per coordinate are filtered to one.
// - Filtered Y is held in a temporary register, not the result register.
// - X is driven and measured only if the pen is still down after Y.
// - X-Y scan ends after X and loads both result registers.
// - X-Y-Z scan goes on to measure Z1 and Z2 the same way.
// - X, Y, Z1 and Z2 load together once all four exist.
// - X-Y scan has two settle phases and two conversion groups.
// - X-Y scan starts with 2.5 oscillator cycles of overhead.
// - Each settle phase adds ten oscillator cycles beyond the intervals.
// - Each conversion takes B+2 converter clocks plus three oscillator cycles.
// - Conversions per coordinate equal N; both fields 00 bypass with N one.
// - Preprocessing delay follows median size, average width and resolution.
// - X-Y-Z scan starts with 3.5 cycles, three settles, four conversion groups.
// - Host-initiated mode only flags the touch until the command arrives.
// - Results sit right-justified, upper bits read zero.
`timescale 1ns/1ps
module tss_core
    import tss_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pen_touch,
    input wire logic [11:0] adc_result,
    output logic drive_y,
    output logic drive_x,
    output logic drive_z,
    output logic adc_power,
    output logic adc_sample,
    output logic adc_res12,
    output logic pen_irq_dataready_pin_n
);
    import tss_pkg::*;

    logic [31:0] ctrl;
    logic [31:0] timing;
    logic [11:0] res_x, res_y, res_z1, res_z2;
    logic [11:0] tmp_x, tmp_y, tmp_z1;
    logic data_avail;
    logic host_start;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire, rd_fire;
    tss_state_t state;
    tss_coord_t coord;
    logic scan_xyz;
    logic [1:0] cfg_med, cfg_avg;
    logic cfg_res12;
    logic [11:0] tcnt;
    logic [7:0] hcnt;
    logic tick;
    logic timer_done;
    logic [4:0] sidx, ridx;
    logic [16:0] fsum;
    logic [11:0] samp [0:MAX_SAMP-1];
    logic [4:0] n_cnt, w_len, sel_lo, rank;
    logic [5:0] ppro_osc;
    logic [11:0] settle_half, conv_half, ppro_half;
    logic [11:0] filt_val;
    logic [11:0] adc_val;
    logic self_start, go;
    logic [3:0] ctrl_func;

    assign ctrl_func = ctrl[FUNC_MSB:FUNC_LSB];

    // Half oscillator tick from the system clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn || hcnt == 8'(HALF_OSC_CYC - 1))
            hcnt <= 8'h00;
        else
            hcnt <= hcnt + 8'h01;
    end
    assign tick = (hcnt == 8'(HALF_OSC_CYC - 1));
    assign timer_done = (tcnt == 12'h000);

    // Filter shape: median size M, average width W and N from the latched codes
    always_comb
    begin
        unique case (cfg_med)
            2'b00: n_cnt = 5'd1;
            2'b01: n_cnt = 5'd3;
            2'b10: n_cnt = 5'd7;
            default: n_cnt = 5'd15;
        endcase
        if (cfg_med == 2'b00)
        begin
            // Plain averaging: W of 1, 4, 8 or 16, N equals W
            unique case (cfg_avg)
                2'b00: w_len = 5'd1;
                2'b01: w_len = 5'd4;
                2'b10: w_len = 5'd8;
                default: w_len = 5'd16;
            endcase
            n_cnt = w_len;
        end
        else
        begin
            unique case (cfg_avg)
                2'b00: w_len = 5'd1;
                2'b01: w_len = 5'd3;
                default: w_len = 5'd7;
            endcase
            // A window wider than the median set is clamped to it
            if (w_len > n_cnt)
                w_len = n_cnt;
        end
        sel_lo = 5'((n_cnt - w_len) >> 1);
    end

    // Preprocessing delay lookup
    always_comb
    begin
        if (cfg_med == 2'b00)
            ppro_osc = PPRO_M1;
        else if (cfg_med == 2'b11)
        begin
            if (w_len == 5'd1)
                ppro_osc = cfg_res12 ? PPRO_M15W1_12 : PPRO_M15W1_10;
            else if (w_len == 5'd3)
                ppro_osc = cfg_res12 ? PPRO_M15W3_12 : PPRO_M15W3_10;
            else
                ppro_osc = cfg_res12 ? PPRO_M15W7_12 : PPRO_M15W7_10;
        end
        else if (cfg_med == 2'b10 && w_len != 5'd1)
            ppro_osc = cfg_res12 ? PPRO_M7W3_12 : PPRO_M7W3_10;
        else
            ppro_osc = cfg_res12 ? PPRO_M3_12 : PPRO_M3_10;
    end

    // Phase lengths in half oscillator cycles
    always_comb
    begin
        settle_half = 12'({4'h0, timing[PVS_LSB +: 8]} + {4'h0, timing[PRE_LSB +: 8]}
            + {4'h0, timing[SNS_LSB +: 8]}) << 1;
        settle_half = settle_half + OH_DLY1_HALF;
        conv_half = 12'((cfg_res12 ? 12'd14 : 12'd12) * ADC_HALF_OSC) + CONVERSION_OVERHEAD_HALF;
        ppro_half = {5'h00, ppro_osc, 1'b0};
    end

    // Rank of the sample under test among the N held; ties broken by index
    always_comb
    begin
        rank = 5'd0;
        for (int j = 0; j < MAX_SAMP; j++)
        begin
            if (5'(j) < n_cnt && (samp[j] < samp[ridx[3:0]]
                || (samp[j] == samp[ridx[3:0]] && 5'(j) < ridx)))
                rank = rank + 5'd1;
        end
    end

    // Average of the W samples ranked around the median
    assign filt_val = 12'(fsum / {12'h000, w_len});
    assign adc_val = cfg_res12 ? adc_result : {2'b00, adc_result[9:0]};

    // Start conditions: own start on touch, or host command
    assign self_start = ctrl[CTRL_AUTO_BIT] && pen_touch
        && (ctrl_func == FUNC_XYZ || ctrl_func == FUNC_XY);
    assign go = (state == ST_IDLE) && (self_start || host_start);

    // Scan sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            coord <= CO_Y;
            scan_xyz <= 1'b0;
            cfg_med <= 2'b00;
            cfg_avg <= 2'b00;
            cfg_res12 <= 1'b1;
            tcnt <= 12'h000;
            sidx <= 5'd0;
            ridx <= 5'd0;
            fsum <= 17'h00000;
        end
        else
        begin
            if (tick && !timer_done)
                tcnt <= tcnt - 12'h001;
            unique case (state)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        state <= ST_OVH;
                        coord <= CO_Y;
                        scan_xyz <= (ctrl_func == FUNC_XYZ);
                        cfg_med <= ctrl[MED_LSB +: 2];
                        cfg_avg <= ctrl[AVG_LSB +: 2];
                        cfg_res12 <= ctrl[CTRL_RES12_BIT];
                        tcnt <= (ctrl_func == FUNC_XYZ) ? OH2_HALF : OH1_HALF;
                    end
                end
                ST_OVH:
                begin
                    if (timer_done)
                    begin
                        state <= ST_SETTLE;
                        tcnt <= settle_half;
                    end
                end
                ST_SETTLE:
                begin
                    if (timer_done)
                    begin
                        state <= ST_CONV;
                        sidx <= 5'd0;
                        tcnt <= conv_half;
                    end
                end
                ST_CONV:
                begin
                    if (timer_done)
                    begin
                        if (sidx == n_cnt - 5'd1)
                        begin
                            state <= ST_PPRO;
                            ridx <= 5'd0;
                            fsum <= 17'h00000;
                            tcnt <= ppro_half;
                        end
                        else
                        begin
                            sidx <= sidx + 5'd1;
                            tcnt <= conv_half;
                        end
                    end
                end
                ST_PPRO:
                begin
                    if (ridx != n_cnt)
                    begin
                        ridx <= ridx + 5'd1;
                        if (rank >= sel_lo && rank < sel_lo + w_len)
                            fsum <= fsum + {5'h00, samp[ridx[3:0]]};
                    end
                    else if (timer_done)
                    begin
                        // Next coordinate only while the pen stays down
                        unique case (coord)
                            CO_Y:
                            begin
                                state <= pen_touch ? ST_SETTLE : ST_IDLE;
                                coord <= CO_X;
                                tcnt <= settle_half;
                            end
                            CO_X:
                            begin
                                state <= (scan_xyz && pen_touch) ? ST_SETTLE : ST_IDLE;
                                coord <= CO_Z1;
                                tcnt <= settle_half;
                            end
                            CO_Z1:
                            begin
                                // Z2 shares the Z1 drive, so no further settle
                                state <= pen_touch ? ST_CONV : ST_IDLE;
                                coord <= CO_Z2;
                                sidx <= 5'd0;
                                tcnt <= conv_half;
                            end
                            CO_Z2:
                            begin
                                state <= ST_IDLE;
                                coord <= CO_Y;
                            end
                        endcase
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Sample capture at the end of each conversion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < MAX_SAMP; i++)
                samp[i] <= 12'h000;
        end
        else if (state == ST_CONV && timer_done)
            samp[sidx[3:0]] <= adc_val;
    end

    // Temporary holding and joint loading of results
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tmp_x <= 12'h000;
            tmp_y <= 12'h000;
            tmp_z1 <= 12'h000;
            res_x <= 12'h000;
            res_y <= 12'h000;
            res_z1 <= 12'h000;
            res_z2 <= 12'h000;
        end
        else if (state == ST_PPRO && ridx == n_cnt && timer_done)
        begin
            unique case (coord)
                CO_Y: tmp_y <= filt_val;
                CO_X:
                begin
                    tmp_x <= filt_val;
                    if (!scan_xyz)
                    begin
                        res_x <= filt_val;
                        res_y <= tmp_y;
                    end
                end
                CO_Z1: tmp_z1 <= filt_val;
                CO_Z2:
                begin
                    res_x <= tmp_x;
                    res_y <= tmp_y;
                    res_z1 <= tmp_z1;
                    res_z2 <= filt_val;
                end
            endcase
        end
    end

    // Analog side controls
    assign drive_y = (state != ST_IDLE) && (coord == CO_Y);
    assign drive_x = (state != ST_IDLE) && (coord == CO_X);
    assign drive_z = (state != ST_IDLE) && (coord == CO_Z1 || coord == CO_Z2);
    assign adc_power = (state == ST_CONV);
    assign adc_sample = (state == ST_CONV) && timer_done;
    assign adc_res12 = cfg_res12;

    // Data-available flag; a new load wins over a status read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            data_avail <= 1'b0;
        else if (state == ST_PPRO && ridx == n_cnt && timer_done
            && (coord == CO_Z2 || (coord == CO_X && !scan_xyz)))
            data_avail <= 1'b1;
        else if (rd_fire && s_axi_araddr == OFF_STAT)
            data_avail <= 1'b0;
    end

    // Pin shows pen touch or data ready, active low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pen_irq_dataready_pin_n <= 1'b1;
        else if (ctrl[CTRL_PENFN_BIT])
            pen_irq_dataready_pin_n <= !pen_touch;
        else
            pen_irq_dataready_pin_n <= !data_avail;
    end

    // AXI write channels, address and data taken in either order
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign wr_fire = aw_hold && w_hold;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr_q)
                    OFF_X, OFF_Y, OFF_Z1, OFF_Z2, OFF_CTRL, OFF_TIME, OFF_STAT:
                        s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Writable registers with byte strobes; a scan function write raises a host start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= CTRL_RESET;
            timing <= TIME_RESET;
            host_start <= 1'b0;
        end
        else
        begin
            if (go)
                host_start <= 1'b0;
            if (wr_fire && aw_addr_q == OFF_CTRL)
            begin
                for (int b = 0; b < 4; b++)
                    if (w_strb_q[b])
                        ctrl[b*8 +: 8] <= w_data_q[b*8 +: 8];
                // Only honoured while idle and with autoscan off
                if (w_strb_q[0] && !w_data_q[CTRL_AUTO_BIT] && state == ST_IDLE
                    && (w_data_q[FUNC_MSB:FUNC_LSB] == FUNC_XYZ
                    || w_data_q[FUNC_MSB:FUNC_LSB] == FUNC_XY))
                    host_start <= 1'b1;
            end
            if (wr_fire && aw_addr_q == OFF_TIME)
            begin
                for (int b = 0; b < 4; b++)
                    if (w_strb_q[b])
                        timing[b*8 +: 8] <= w_data_q[b*8 +: 8];
            end
        end
    end

    // AXI read channel, one cycle answer
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                OFF_X: s_axi_rdata <= {20'h00000, res_x};
                OFF_Y: s_axi_rdata <= {20'h00000, res_y};
                OFF_Z1: s_axi_rdata <= {20'h00000, res_z1};
                OFF_Z2: s_axi_rdata <= {20'h00000, res_z2};
                OFF_CTRL: s_axi_rdata <= ctrl;
                OFF_TIME: s_axi_rdata <= timing;
                OFF_STAT: s_axi_rdata <= {29'h00000000, data_avail, pen_touch, state != ST_IDLE};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule : tss_core

// >>> sim/tss_properties.sv
/* Port checker for the touch scan sequencer.
   Bound to tss_core from tb_top; sees only the core's ports. */
`timescale 1ns/1ps
module tss_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pen_touch,
    input wire logic drive_y,
    input wire logic drive_x,
    input wire logic drive_z,
    input wire logic adc_power,
    input wire logic adc_sample
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus answers and holds
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // Panel drive sequencing; one axis at a time avoids shorting the sheets
    a_one_axis: assert property ($onehot0({drive_x, drive_y, drive_z}))
        else $error("two axes driven");
    a_sample_pulse: assert property (adc_sample |-> adc_power ##1 !adc_sample)
        else $error("sample outside conversion");
    a_power_driven: assert property (adc_power |-> drive_x || drive_y || drive_z)
        else $error("converter on without driver");
    a_x_needs_pen: assert property ($rose(drive_x) |-> $past(pen_touch))
        else $error("x driven without pen");
    a_z_after_x: assert property ($rose(drive_z) |-> $past(drive_x))
        else $error("pressure not after x");
endmodule : tss_properties

// >>> sim/tss_panel.sv
/* Panel and converter model: gives a fixed reading per driven axis.
   Assumes drivers are level signals synchronous to aclk. */
`timescale 1ns/1ps
module tss_panel (
    input wire logic aclk,
    input wire logic drive_y,
    input wire logic drive_x,
    input wire logic drive_z,
    input wire logic [11:0] base,
    output logic [11:0] adc_result
);
    // Undriven panel floats, so the reading keeps toggling
    always_ff @(posedge aclk)
    begin
        if (drive_y)
            adc_result <= base + 12'h123;
        else if (drive_x)
            adc_result <= base + 12'h256;
        else if (drive_z)
            adc_result <= base + 12'h0a5;
        else
            adc_result <= ~adc_result;
    end
endmodule : tss_panel

// >>> sim/tb_top.sv
/* Self-checking bench for tss_core over AXI4-Lite.
   Assumes tss_panel as the panel and the checker bound below. */
`timescale 1ns/1ps
module tb_top;
    import tss_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pen_touch = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [11:0] adc_result, base = 12'h000;
    logic drive_y, drive_x, drive_z, adc_power, adc_sample, adc_res12, pen_irq_dataready_pin_n;
    int bad_count = 0, n_compared = 0, cyc = 0;
    tss_core u_dut (.*);
    tss_panel u_panel (.aclk(aclk), .drive_y(drive_y), .drive_x(drive_x), .drive_z(drive_z),
        .base(base), .adc_result(adc_result));
    initial forever #2 aclk = ~aclk;
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // Hang guard
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Address and data offered together, each released once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(ta && tw))
        begin
            @(negedge aclk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        s_axi_bready <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(negedge aclk); while (s_axi_arready !== 1'h1);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask : rd
    // Poll one status bit until it shows the wanted level
    task poll(input int b, input logic e);
        do rd(OFF_STAT, v); while (v[b] !== e);
    endtask : poll
    task chk_res(input logic [31:0] x, input logic [31:0] y, input logic [31:0] z);
        rd(OFF_X, v);
        chk("x", v, x);
        rd(OFF_Y, v);
        chk("y", v, y);
        rd(OFF_Z1, v);
        chk("z1", v, z);
        rd(OFF_Z2, v);
        chk("z2", v, z);
    endtask : chk_res
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFF_CTRL, v);
        chk("ctrl", v, CTRL_RESET);
        rd(8'h1c, v);
        chk("unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(OFF_TIME, 32'h0); // Shortest intervals keep the run brief
        chk("wresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        wr(8'h1c, 32'h0);
        chk("wr unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        // Self-started X-Y scan, 10-bit, pin as pen interrupt
        wr(OFF_CTRL, 32'h89);
        pen_touch <= 1'h1;
        repeat (3) @(negedge aclk);
        chk("pin", {31'h0, pen_irq_dataready_pin_n}, 32'h0);
        poll(STAT_DAV_BIT, 1'h1);
        pen_touch <= 1'h0;
        poll(STAT_BUSY_BIT, 1'h0);
        chk_res(32'h256, 32'h123, 32'h0);
        // Host mode: touch only flags until the scan code is written
        wr(OFF_CTRL, 32'h178);
        pen_touch <= 1'h1;
        repeat (50) @(posedge aclk);
        rd(OFF_STAT, v);
        chk("flag only", v[1:0], 32'h2);
        chk("pin off", {31'h0, pen_irq_dataready_pin_n}, 32'h1);
        wr(OFF_CTRL, 32'h300);
        poll(STAT_DAV_BIT, 1'h1);
        chk_res(32'h256, 32'h123, 32'h0a5);
        // Pen lifted during x abandons the scan
        base <= 12'h011;
        wr(OFF_CTRL, 32'h300);
        do @(negedge aclk); while (drive_x !== 1'h1);
        @(posedge aclk);
        pen_touch <= 1'h0;
        poll(STAT_BUSY_BIT, 1'h0);
        chk("no data", {31'h0, v[STAT_DAV_BIT]}, 32'h0);
        chk_res(32'h256, 32'h123, 32'h0a5);
        print_verdict();
    end
endmodule : tb_top
bind tss_core tss_properties u_chk (.*);
